// ---- design/usbsof_frame_timer.sv ----
// host start-of-frame timer with its shared low, high/control and enable registers
`timescale 1ns/1ps
`default_nettype none
`include "usbsof_map.svh"
module usbsof_frame_timer #(
  parameter logic [3:0] HW_REVISION = 4'h3, // arbitrary value
  parameter int CLK_KHZ = `USBSOF_SYS_CLK_KHZ,
  parameter int TICK_KHZ = `USBSOF_TICK_KHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic set_b_request,
  output logic set_b_active,
  output logic host_mode,
  output logic polarity_swap,
  output logic ext_features_en,
  output logic sof_gen_enable,
  output logic sof_tick,
  output logic [10:0] frame_number,
  output logic [13:0] remaining_time_count
);
  localparam int CNT_MSB = `USBSOF_THIGH_CNT_MSB;
  localparam int RD_SHIFT = `USBSOF_CNT_READ_SHIFT;

  usbsof_timer_if tif ();

  logic [7:0] tlow_q;
  logic [CNT_MSB:0] thigh_q;
  logic role_q;
  logic pol_q;
  logic ext_en_q;
  logic sof_en_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic tick_12m;

  // address decode
  wire logic sel_ctrl1 = reg_addr == `USBSOF_ADDR_CTRL1;
  wire logic sel_tlow = reg_addr == `USBSOF_ADDR_TLOW;
  wire logic sel_thigh = reg_addr == `USBSOF_ADDR_THIGH;
  wire logic wr_ctrl1 = reg_wr && sel_ctrl1;
  wire logic wr_tlow = reg_wr && sel_tlow;
  wire logic wr_thigh = reg_wr && sel_thigh;

  // read path: low address shows revision, high address shows count bits 13..6
  wire logic [7:0] rev_byte = {HW_REVISION, 4'h0};
  wire logic [7:0] cnt_byte = tif.count[13:RD_SHIFT];
  wire logic [7:0] ctrl1_byte = {7'h00, sof_en_q};

  always_comb begin
    rdata_d = `USBSOF_RST_BYTE;
    if (sel_tlow) begin
      rdata_d = rev_byte;
    end else if (sel_thigh) begin
      rdata_d = cnt_byte;
    end else if (sel_ctrl1) begin
      rdata_d = ctrl1_byte;
    end
  end

  usbsof_tick_gen #(
    .CLK_KHZ(CLK_KHZ),
    .TICK_KHZ(TICK_KHZ)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick_12m)
  );

  usbsof_frame_core u_core (
    .sys_clk(sys_clk),
    .rst(rst),
    .tif(tif.tmr)
  );

  assign tif.tick_12m = tick_12m;
  assign tif.run = sof_en_q;
  assign tif.frame_clear = wr_thigh;
  assign tif.reload = {thigh_q, tlow_q};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tlow_q <= `USBSOF_RST_TLOW;
    end else if (wr_tlow) begin
      tlow_q <= reg_wdata;
    end
  end

  // one write carries role, polarity and upper reload bits together
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      thigh_q <= `USBSOF_RST_THIGH;
      role_q <= 1'b0;
      pol_q <= 1'b0;
    end else if (wr_thigh) begin
      thigh_q <= reg_wdata[CNT_MSB:0];
      role_q <= reg_wdata[`USBSOF_THIGH_ROLE_BIT];
      pol_q <= reg_wdata[`USBSOF_THIGH_POL_BIT];
    end
  end

  // extended features cannot be turned off again short of a reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_en_q <= 1'b0;
    end else if (wr_thigh) begin
      ext_en_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sof_en_q <= 1'b0;
    end else if (wr_ctrl1) begin
      sof_en_q <= reg_wdata[`USBSOF_CTRL1_SOF_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= `USBSOF_RST_BYTE;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign set_b_active = set_b_request && ext_en_q;
  assign host_mode = role_q;
  assign polarity_swap = pol_q;
  assign ext_features_en = ext_en_q;
  assign sof_gen_enable = sof_en_q;
  assign sof_tick = tif.sof_pulse;
  assign frame_number = tif.frame_no;
  assign remaining_time_count = tif.count;

  // checks
  localparam int TICK_GAP = `USBSOF_TICK_MIN_GAP;
  logic [3:0] gap_cnt_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap_cnt_q <= 4'h0;
    end else if (tick_12m) begin
      gap_cnt_q <= 4'h0;
    end else if (gap_cnt_q != 4'hF) begin
      gap_cnt_q <= gap_cnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_thigh_write;
    wr_thigh;
  endsequence

  sequence s_ext_held;
    ext_en_q [*3];
  endsequence

  chk_low_store: assert property (wr_tlow |=> tlow_q == $past(reg_wdata))
    else $error("low reload byte not stored");

  chk_high_store: assert property (wr_thigh |=> thigh_q == $past(reg_wdata[CNT_MSB:0]))
    else $error("upper reload bits not stored");

  chk_count_step: assert property (
    tif.run && $past(tif.run) && tick_12m && tif.count != 14'h0000 && !$past(wr_ctrl1)
    |=> tif.count == $past(tif.count) - 14'h0001)
    else $error("timer did not decrement on tick");

  chk_count_hold: assert property (tif.run && !tick_12m && $past(tif.run) |=> $stable(tif.count) || !tif.run)
    else $error("timer moved without a tick");

  chk_read_high: assert property (reg_rd && sel_thigh |=> reg_rdata == $past(tif.count[13:RD_SHIFT]))
    else $error("high read is not count divided by 64");

  chk_frame_clear: assert property (s_thigh_write |=> frame_number == 11'h000)
    else $error("frame number not cleared by high write");

  chk_frame_step: assert property (tif.sof_fire && !wr_thigh |=> frame_number == $past(frame_number) + 11'h001)
    else $error("frame number did not advance");

  chk_sof_frame: assert property (sof_tick |-> $past(tif.sof_fire) && !$past(wr_thigh) |-> frame_number != $past(frame_number))
    else $error("sof tick without new frame number");

  chk_role_sel: assert property (wr_thigh |=> host_mode == $past(reg_wdata[`USBSOF_THIGH_ROLE_BIT]))
    else $error("role bit not applied");

  chk_pol_swap: assert property (wr_thigh |=> polarity_swap == $past(reg_wdata[`USBSOF_THIGH_POL_BIT]))
    else $error("polarity bit not applied");

  chk_ext_set: assert property (s_thigh_write |=> s_ext_held)
    else $error("extended enable not set by high write");

  chk_set_b_gate: assert property (set_b_active |-> ext_features_en && set_b_request)
    else $error("second set used without extended features");

  chk_sof_enable: assert property (sof_tick |-> $past(sof_gen_enable))
    else $error("sof generated while disabled");

  // on a tick the counter already reads one less than the spacing, so the current value is the one to test
  chk_tick_gap: assert property (tick_12m && gap_cnt_q != 4'hF |-> gap_cnt_q >= 4'(TICK_GAP))
    else $error("12 MHz tick spacing too short");

  chk_tick_bound: assert property (gap_cnt_q <= 4'hB)
    else $error("12 MHz tick missing");

  chk_reload_zero: assert property (tif.sof_fire && !wr_tlow && !wr_thigh |=> tif.count == tif.reload)
    else $error("timer did not reload after zero");

  chk_fire_zero: assert property (tif.sof_fire |-> tif.count == 14'h0000 && tick_12m)
    else $error("sof fired away from zero");

  // each register moves only on its own strobe
  chk_low_hold: assert property (!wr_tlow |=> $stable(tlow_q))
    else $error("low reload byte changed without a write");

  chk_high_hold: assert property (!wr_thigh |=> $stable(thigh_q))
    else $error("upper reload bits changed without a write");

  chk_role_hold: assert property (!wr_thigh |=> $stable(host_mode) && $stable(polarity_swap))
    else $error("role or polarity changed without a write");

  chk_sof_en_store: assert property (
    wr_ctrl1 |=> sof_gen_enable == $past(reg_wdata[`USBSOF_CTRL1_SOF_EN_BIT]))
    else $error("sof enable bit not stored");

  chk_sof_en_hold: assert property (!wr_ctrl1 |=> $stable(sof_gen_enable))
    else $error("sof enable changed without a write");

  chk_idle_no_sof: assert property (!tif.run |-> !tif.sof_fire)
    else $error("frame fired while generation is off");

  chk_idle_follow: assert property (!tif.run |=> tif.count == $past(tif.reload))
    else $error("stopped timer does not track the reload");

  chk_zero_fires: assert property (
    tif.run && $past(tif.run) && tick_12m && tif.count == 14'h0000 |-> tif.sof_fire)
    else $error("timer at zero did not fire on a tick");

  sequence s_fire_then_pulse;
    tif.sof_fire ##1 sof_tick;
  endsequence

  chk_fire_pulse: assert property (tif.sof_fire |-> s_fire_then_pulse)
    else $error("frame end gave no sof pulse");

  chk_sof_single: assert property (sof_tick |=> !sof_tick)
    else $error("sof pulse longer than one cycle");

  chk_frame_hold: assert property (!tif.sof_fire && !wr_thigh |=> $stable(frame_number))
    else $error("frame number moved without a tick or clear");

  chk_ext_sticky: assert property (ext_features_en |=> ext_features_en)
    else $error("extended enable dropped");

  chk_ext_cause: assert property ($rose(ext_features_en) |-> $past(wr_thigh))
    else $error("extended enable set without a high write");

  chk_set_b_off: assert property (!ext_features_en |-> !set_b_active)
    else $error("second set active with extended features off");

  chk_read_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  chk_read_ctrl1: assert property (reg_rd && sel_ctrl1 |=> reg_rdata == {7'h00, $past(sof_gen_enable)})
    else $error("first control register read wrong");

  chk_read_low: assert property (reg_rd && sel_tlow |=> reg_rdata == {HW_REVISION, 4'h0})
    else $error("low address read is not the revision");

  chk_read_unmapped: assert property (reg_rd && !sel_tlow && !sel_thigh && !sel_ctrl1 |=> reg_rdata == 8'h00)
    else $error("unmapped address read not zero");

  // the fractional divider spaces its pulses ten or eleven clocks apart
  sequence s_tick_quiet;
    (!tick_12m) [*8];
  endsequence

  chk_tick_quiet: assert property (tick_12m |=> s_tick_quiet)
    else $error("12 MHz ticks too close together");

  chk_tick_next: assert property (tick_12m |-> ##[10:11] tick_12m)
    else $error("12 MHz tick spacing out of range");
endmodule
`default_nettype wire

// ---- design/usbsof_map.svh ----
// register offsets, field positions, reset values and timing figures of the frame timer
`ifndef USBSOF_MAP_SVH
`define USBSOF_MAP_SVH

`define USBSOF_ADDR_CTRL1 8'h05
`define USBSOF_ADDR_TLOW 8'h0E
`define USBSOF_ADDR_THIGH 8'h0F

`define USBSOF_CTRL1_SOF_EN_BIT 0
`define USBSOF_THIGH_ROLE_BIT 7
`define USBSOF_THIGH_POL_BIT 6
`define USBSOF_THIGH_CNT_MSB 5
`define USBSOF_CNT_READ_SHIFT 6
`define USBSOF_REV_MSB 7
`define USBSOF_REV_LSB 4

`define USBSOF_RST_TLOW 8'h00
`define USBSOF_RST_THIGH 6'h00
`define USBSOF_RST_BYTE 8'h00
`define USBSOF_RST_FRAME 11'h000
`define USBSOF_RST_COUNT 14'h0000

`define USBSOF_SYS_CLK_KHZ 125000
`define USBSOF_TICK_KHZ 12000
`define USBSOF_TICK_MIN_GAP 9

`endif

// ---- design/usbsof_pkg.sv ----
// types shared by the frame timer modules
package usbsof_pkg;
  typedef logic [13:0] usbsof_count_t;
  typedef logic [10:0] usbsof_frame_t;
  typedef enum logic [0:0] {
    USBSOF_TMR_IDLE = 1'b0,
    USBSOF_TMR_RUN = 1'b1
  } usbsof_tmr_state_t;
endpackage

// ---- design/usbsof_timer_if.sv ----
// signals between the register front end and the frame timer core
`timescale 1ns/1ps
`default_nettype none
interface usbsof_timer_if;
  logic tick_12m;
  logic run;
  logic frame_clear;
  usbsof_pkg::usbsof_count_t reload;
  usbsof_pkg::usbsof_count_t count;
  usbsof_pkg::usbsof_frame_t frame_no;
  logic sof_pulse;
  logic sof_fire;
  modport ctl (
    output tick_12m,
    output run,
    output frame_clear,
    output reload,
    input count,
    input frame_no,
    input sof_pulse,
    input sof_fire
  );
  modport tmr (
    input tick_12m,
    input run,
    input frame_clear,
    input reload,
    output count,
    output frame_no,
    output sof_pulse,
    output sof_fire
  );
endinterface
`default_nettype wire

// ---- design/usbsof_tick_gen.sv ----
// fractional divider giving one enable pulse per 12 MHz period on average
`timescale 1ns/1ps
`default_nettype none
`include "usbsof_map.svh"
module usbsof_tick_gen #(
  parameter int CLK_KHZ = `USBSOF_SYS_CLK_KHZ,
  parameter int TICK_KHZ = `USBSOF_TICK_KHZ,
  parameter int ACC_W = 18
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic tick
);
  localparam logic [ACC_W:0] STEP = (ACC_W+1)'(TICK_KHZ);
  localparam logic [ACC_W:0] MODULUS = (ACC_W+1)'(CLK_KHZ);
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic tick_q;
  wire logic [ACC_W:0] sum = {1'b0, acc_q} + STEP;
  wire logic wrap = sum >= MODULUS;
  wire logic [ACC_W:0] sum_wrapped = sum - MODULUS;

  // rate comes from the system clock, never from the crystal choice
  assign acc_d = wrap ? sum_wrapped[ACC_W-1:0] : sum[ACC_W-1:0];
  assign tick = tick_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= wrap;
    end
  end
endmodule
`default_nettype wire

// ---- design/usbsof_frame_core.sv ----
// 14-bit frame down-counter and 11-bit frame number
`timescale 1ns/1ps
`default_nettype none
`include "usbsof_map.svh"
module usbsof_frame_core (
  input wire logic sys_clk,
  input wire logic rst,
  usbsof_timer_if.tmr tif
);
  usbsof_pkg::usbsof_tmr_state_t state_q;
  usbsof_pkg::usbsof_count_t count_q;
  usbsof_pkg::usbsof_frame_t frame_q;
  logic sof_q;
  wire logic at_zero = count_q == `USBSOF_RST_COUNT;
  wire logic running = (state_q == usbsof_pkg::USBSOF_TMR_RUN) && tif.run;
  wire logic fire = running && tif.tick_12m && at_zero;
  wire logic step = running && tif.tick_12m && !at_zero;
  wire usbsof_pkg::usbsof_count_t count_dec = count_q - 14'h0001;
  wire usbsof_pkg::usbsof_frame_t frame_inc = frame_q + 11'h001;

  assign tif.count = count_q;
  assign tif.frame_no = frame_q;
  assign tif.sof_pulse = sof_q;
  assign tif.sof_fire = fire;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= usbsof_pkg::USBSOF_TMR_IDLE;
    end else begin
      unique case (state_q)
        usbsof_pkg::USBSOF_TMR_IDLE: begin
          if (tif.run) begin
            state_q <= usbsof_pkg::USBSOF_TMR_RUN;
          end
        end
        usbsof_pkg::USBSOF_TMR_RUN: begin
          if (!tif.run) begin
            state_q <= usbsof_pkg::USBSOF_TMR_IDLE;
          end
        end
      endcase
    end
  end

  // while idle the counter tracks the reload so a fresh start gives a full frame
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= `USBSOF_RST_COUNT;
    end else if (!running || fire) begin
      count_q <= tif.reload;
    end else if (step) begin
      count_q <= count_dec;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_q <= `USBSOF_RST_FRAME;
      sof_q <= 1'b0;
    end else begin
      sof_q <= fire;
      if (tif.frame_clear) begin
        frame_q <= `USBSOF_RST_FRAME;
      end else if (fire) begin
        frame_q <= frame_inc;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/usbsof_peer_model.sv ----
// peripheral stand-in that records the frame number carried by each start-of-frame
`timescale 1ns/1ps
`default_nettype none
module usbsof_peer_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sof_tick,
  input wire logic [10:0] frame_number,
  output logic [15:0] pkt_count,
  output logic [10:0] last_frame
);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pkt_count <= 16'h0000;
      last_frame <= 11'h000;
    end else if (sof_tick) begin
      pkt_count <= pkt_count + 16'h0001;
      last_frame <= frame_number;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the start-of-frame timer and its shared registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [3:0] REV = 4'h3; // arbitrary value
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic set_b_request = 1'b1;
  logic [7:0] reg_rdata;
  logic set_b_active, host_mode, polarity_swap, ext_features_en, sof_gen_enable, sof_tick;
  logic [10:0] frame_number;
  logic [13:0] remaining_time_count;
  logic [15:0] pkt_count;
  logic [10:0] last_frame;
  logic rd_pend = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] lo, hi;
  int mismatches = 0;
  int total_checks = 0;
  int n;

  always #4 sys_clk = ~sys_clk;

  usbsof_frame_timer #(.HW_REVISION(REV)) DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .set_b_request(set_b_request), .set_b_active(set_b_active), .host_mode(host_mode),
    .polarity_swap(polarity_swap), .ext_features_en(ext_features_en), .sof_gen_enable(sof_gen_enable),
    .sof_tick(sof_tick), .frame_number(frame_number), .remaining_time_count(remaining_time_count));

  usbsof_peer_model peer (.sys_clk(sys_clk), .rst(rst), .sof_tick(sof_tick), .frame_number(frame_number),
    .pkt_count(pkt_count), .last_frame(last_frame));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // expected read data is queued here and compared by the watcher below
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
  endtask

  // read data is registered, so it is looked at half a cycle after the read edge
  always @(posedge sys_clk) rd_pend <= reg_rd & ~rst;
  always @(negedge sys_clk) begin
    if (rd_pend && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
  end

  // bounded wait for the next frame pulse; n counts the edges waited
  task automatic wait_sof();
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (sof_tick !== 1'b1 && n < 400);
    chk(sof_tick, 1'b1);
  endtask

  initial begin
    void'($urandom(25852));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk({host_mode, polarity_swap, ext_features_en, sof_gen_enable, sof_tick}, 5'h00);
    chk(set_b_active, 1'b0);
    rd(8'h0E, {REV, 4'h0});
    rd(8'h05, 8'h00);
    rd(8'h0F, 8'h00);
    wr(8'h07, 8'h5A);
    rd(8'h07, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lo = 8'($urandom);
      hi = {i[1:0], 6'($urandom)};
      wr(8'h0E, lo);
      wr(8'h0F, hi);
      chk({host_mode, polarity_swap, ext_features_en, set_b_active}, {hi[7:6], 2'b11});
      rd(8'h0F, {hi[5:0], lo[7:6]});
      chk(remaining_time_count, {hi[5:0], lo});
    end
    // features on but no request from the transfer logic: the second set stays idle
    @(posedge sys_clk);
    set_b_request <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(set_b_active, 1'b0);
    @(posedge sys_clk);
    set_b_request <= 1'b1;
    wr(8'h0E, 8'hE0);
    wr(8'h0F, 8'hAE);
    rd(8'h0F, 8'hBB);
    chk({host_mode, polarity_swap}, 2'b10);
    // short reload keeps frames near sixty clocks
    wr(8'h0E, 8'h05);
    wr(8'h0F, 8'h80);
    repeat (100) @(posedge sys_clk);
    #1;
    chk(pkt_count, 16'h0000);
    wr(8'h05, 8'h01);
    rd(8'h05, 8'h01);
    chk(sof_gen_enable, 1'b1);
    wait_sof();
    chk(frame_number, 11'h001);
    chk(remaining_time_count, 14'h0005);
    @(posedge sys_clk);
    #1;
    chk(sof_tick, 1'b0);
    wait_sof();
    chk(14'(n >= 59 && n <= 65), 14'h0001);
    chk(frame_number, 11'h002);
    wr(8'h0F, 8'h80);
    chk(frame_number, 11'h000);
    chk({pkt_count[10:0], last_frame}, {11'h002, 11'h002});
    rd(8'h0F, 8'h00);
    wr(8'h05, 8'h00);
    repeat (100) @(posedge sys_clk);
    #1;
    chk(pkt_count, 16'h0002);
    chk(remaining_time_count, 14'h0005);
    report_and_stop();
  end

  initial begin
    #(8 * 20000);
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
